// ===== design/acp_cmd_port.sv
// Serial command interpreter and shared data/ready output of the converter.
//
// Operation
// - Shared output pin floats whenever chip select is high.
// - Select bit zero: pin is plain data out, MSB first on rising clock.
// - Select bit one: pin carries data and the conversion-ready indication.
// - No ready indication on the shared pin in stop-continuous-read mode.
// - Select bit never changes the dedicated ready pin.
// - Ready mode: on new data the shared pin falls, pulsing high first if already low.
// - Ready mode: pin forced high on first rising clock after data ends.
// - Chip select high resets the serial logic, not registers or filter.
// - Hardware reset pin low resets everything and restarts conversion.
// - Serial logic resets itself after 64 idle conversion cycles.
// - Stopped or powered down: only read, mode, power-up and no-op act.
// - Results are 24-bit two's complement.
// - Results saturate at 7fffff and 800000.
// - Decode power-up, power-down, resync and soft reset bytes, bit 0 ignored.
// - Decode read-once, continuous-read and stop-read bytes, bit 0 ignored.
// - Register access: opcode with start address, then count byte plus one.
// - Byte ff is a no-op; the host never sends f1.
// - Power-up takes effect at the eighth falling clock of its byte.
// - Power-down finishes the running conversion; reference stays per its bits.
// - Decode system offset, system gain and internal offset calibration.
// - Continuous read is the active mode after i_srst, the hardware reset pin or soft reset.
`timescale 1ns/1ps
module acp_cmd_port
#(
  parameter int RAW_W = 26
)
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Serial and control pins
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_din,
  input wire logic i_reset_n,
  input wire logic i_start,
  output logic o_dout,
  output logic o_dout_oe,
  output logic o_conversion_ready_pin_n,
  // Converter core
  input wire logic i_conv_done,
  input wire logic signed [RAW_W-1:0] i_conv_raw,
  output logic o_conv_run,
  output logic o_filter_restart,
  output logic o_cal_start,
  output acp_pkg::acp_cal_t o_cal_kind,
  output logic [acp_pkg::REF_W-1:0] o_ref_ctrl
);
  import acp_pkg::*;

  // The raw value must be wider than the result for the saturation test.
  function automatic logic [RES_W-1:0] clip_result(input logic [RAW_W-1:0] raw);
    logic [RAW_W-RES_W:0] top;
    top = raw[RAW_W-1:RES_W-1];
    if ((&top) || !(|top))
      clip_result = raw[RES_W-1:0];
    else if (raw[RAW_W-1])
      clip_result = RES_MIN;
    else
      clip_result = RES_MAX;
  endfunction : clip_result

  logic [4:0] pin_s;
  logic cs_n_s;
  logic sclk_s;
  logic din_s;
  logic reset_n_s;
  logic start_s;
  logic rst_all;
  logic sclk_prev;
  logic sclk_rise;
  logic sclk_fall;

  acp_pin_sync #(.W(5), .RST_VAL(PIN_RST)) u_pin_sync (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_async({i_start, i_reset_n, i_din, i_sclk, i_cs_n}),
    .o_sync(pin_s)
  );

  assign cs_n_s = pin_s[0];
  assign sclk_s = pin_s[1];
  assign din_s = pin_s[2];
  assign reset_n_s = pin_s[3];
  assign start_s = pin_s[4];
  assign rst_all = i_srst | ~reset_n_s;
  assign sclk_rise = sclk_s & ~sclk_prev;
  assign sclk_fall = ~sclk_s & sclk_prev;

  acp_state_t state, next_state;
  logic [2:0] bitcnt, next_bitcnt;
  logic [6:0] in_sh, next_in_sh;
  logic [RES_W-1:0] sh_out, next_sh_out;
  logic [4:0] out_bits, next_out_bits;
  logic [3:0] reg_addr, next_reg_addr;
  logic [3:0] reg_left, next_reg_left;
  logic reg_wr, next_reg_wr;
  logic [7:0] regs [NREG];
  logic [7:0] next_regs [NREG];
  logic [RES_W-1:0] result, next_result;
  logic cont_rd, next_cont_rd;
  logic mode_pend, next_mode_pend;
  logic mode_val, next_mode_val;
  logic powered, next_powered;
  logic sleep_pend, next_sleep_pend;
  logic [6:0] idle_cnt, next_idle_cnt;
  logic dout_pulse, next_dout_pulse;
  logic conversion_ready_pin_pulse, next_conversion_ready_pin_pulse;
  logic next_dout;
  logic next_dout_oe;
  logic next_conversion_ready_pin_n;
  logic next_conv_run;
  logic next_filter_restart;
  logic next_cal_start;
  acp_cal_t next_cal_kind;
  logic [REF_W-1:0] next_ref_ctrl;

  always_comb
  begin
    logic [7:0] byte_in;
    logic low_power;
    logic rdy_sel;
    logic new_cont;
    logic mode_cmd;
    logic soft_rst;
    byte_in = {in_sh, din_s};
    mode_cmd = 1'b0;
    soft_rst = 1'b0;
    low_power = ~powered | ~start_s;
    rdy_sel = regs[RDY_SEL_IDX][RDY_SEL_BIT];
    new_cont = mode_pend ? mode_val : cont_rd;
    next_state = state;
    next_bitcnt = bitcnt;
    next_in_sh = in_sh;
    next_sh_out = sh_out;
    next_out_bits = out_bits;
    next_reg_addr = reg_addr;
    next_reg_left = reg_left;
    next_reg_wr = reg_wr;
    next_regs = regs;
    next_result = result;
    next_cont_rd = cont_rd;
    next_mode_pend = mode_pend;
    next_mode_val = mode_val;
    next_powered = powered;
    next_sleep_pend = sleep_pend;
    next_idle_cnt = idle_cnt;
    next_dout = o_dout;
    next_dout_pulse = 1'b0;
    next_conversion_ready_pin_n = o_conversion_ready_pin_n;
    next_conversion_ready_pin_pulse = 1'b0;
    next_dout_oe = ~cs_n_s;
    next_filter_restart = 1'b0;
    next_cal_start = 1'b0;
    next_cal_kind = o_cal_kind;

    // Second half of a high-then-low ready pulse.
    if (dout_pulse)
      next_dout = 1'b0;
    if (conversion_ready_pin_pulse)
      next_conversion_ready_pin_n = 1'b0;

    // The dedicated ready pin is released by any falling clock, selected or not.
    if (sclk_fall)
      next_conversion_ready_pin_n = 1'b1;

    if (sclk_rise)
    begin
      if (out_bits != 5'h00)
      begin
        next_dout = sh_out[RES_W-1];
        next_sh_out = {sh_out[RES_W-2:0], 1'b0};
        next_out_bits = out_bits - 5'h01;
      end
      else if (rdy_sel && cont_rd)
        next_dout = 1'b1;
      else
        next_dout = 1'b0;
    end

    if (sclk_fall && !cs_n_s)
    begin
      next_in_sh = byte_in[6:0];
      next_bitcnt = bitcnt + 3'h1;
      if (bitcnt == BYTE_LAST)
      begin
        case (state)
          ST_CMD:
          begin
            if (byte_in[7:1] == OP_POWER_UP)
            begin
              next_powered = 1'b1;
              next_sleep_pend = 1'b0;
            end
            else if (byte_in[7:1] == OP_READ_ONCE)
            begin
              next_sh_out = result;
              next_out_bits = RES_BITS;
            end
            else if (byte_in[7:1] == OP_CONT_READ)
            begin
              next_mode_pend = 1'b1;
              next_mode_val = 1'b1;
              mode_cmd = 1'b1;
            end
            else if (byte_in[7:1] == OP_STOP_READ)
            begin
              next_mode_pend = 1'b1;
              next_mode_val = 1'b0;
              mode_cmd = 1'b1;
            end
            else if (low_power || byte_in == NO_OPERATION_BYTE)
            begin
              next_state = ST_CMD;
            end
            else if (byte_in[7:1] == OP_POWER_DOWN)
              next_sleep_pend = 1'b1;
            else if (byte_in[7:1] == OP_RESYNC)
              next_filter_restart = 1'b1;
            else if (byte_in[7:1] == OP_SOFT_RESET)
            begin
              for (int i = 0; i < NREG; i++)
                next_regs[i] = REG_DFLT;
              next_filter_restart = 1'b1;
              next_cont_rd = 1'b1;
              soft_rst = 1'b1;
              next_mode_pend = 1'b0;
            end
            else if (byte_in[7:4] == NIB_REG_READ || byte_in[7:4] == NIB_REG_WRITE)
            begin
              next_state = ST_COUNT;
              next_reg_addr = byte_in[3:0];
              next_reg_wr = (byte_in[7:4] == NIB_REG_WRITE);
            end
            else if (byte_in == CMD_SYS_OFS_CAL)
            begin
              next_cal_start = 1'b1;
              next_cal_kind = CAL_SYS_OFS;
            end
            else if (byte_in == CMD_SYS_GAIN_CAL)
            begin
              next_cal_start = 1'b1;
              next_cal_kind = CAL_SYS_GAIN;
            end
            else if (byte_in == CMD_INT_OFS_CAL)
            begin
              next_cal_start = 1'b1;
              next_cal_kind = CAL_INT_OFS;
            end
            // Anything else, the reserved byte included, leaves all state alone.
            else
              next_state = ST_CMD;
          end
          ST_COUNT:
          begin
            next_reg_left = byte_in[3:0];
            if (byte_in[7:4] != NIB_COUNT)
              next_state = ST_CMD;
            else if (reg_wr)
              next_state = ST_WDATA;
            else
            begin
              next_state = ST_RDOUT;
              next_sh_out = {regs[reg_addr], 16'h0000};
              next_out_bits = BYTE_BITS;
            end
          end
          ST_WDATA:
          begin
            next_regs[reg_addr] = byte_in;
            next_reg_addr = reg_addr + 4'h1;
            next_reg_left = reg_left - 4'h1;
            if (reg_left == 4'h0)
              next_state = ST_CMD;
          end
          ST_RDOUT:
          begin
            // Bytes clocked in during read-back are ignored as commands.
            next_reg_addr = reg_addr + 4'h1;
            next_reg_left = reg_left - 4'h1;
            if (reg_left == 4'h0)
              next_state = ST_CMD;
            else
            begin
              next_sh_out = {regs[reg_addr + 4'h1], 16'h0000};
              next_out_bits = BYTE_BITS;
            end
          end
          default:
            next_state = ST_CMD;
        endcase
      end
    end

    // Idle timeout counts conversions with no clock activity.
    if (sclk_rise || sclk_fall)
      next_idle_cnt = 7'h00;
    else if (i_conv_done && idle_cnt != IDLE_TIMEOUT)
      next_idle_cnt = idle_cnt + 7'h01;

    if (cs_n_s || idle_cnt == IDLE_TIMEOUT)
    begin
      next_state = ST_CMD;
      next_bitcnt = 3'h0;
      next_in_sh = 7'h00;
      next_out_bits = 5'h00;
      next_idle_cnt = 7'h00;
    end

    // A result landing mid-transfer in continuous-read mode overwrites the output register by design.
    if (i_conv_done)
    begin
      next_result = clip_result(i_conv_raw);
      // A command decoded in the same cycle as a result must not be lost.
      if (!soft_rst)
        next_cont_rd = new_cont;
      if (!mode_cmd)
        next_mode_pend = 1'b0;
      if (sleep_pend && next_sleep_pend)
      begin
        next_powered = 1'b0;
        next_sleep_pend = 1'b0;
      end
      if (new_cont)
      begin
        next_sh_out = clip_result(i_conv_raw);
        next_out_bits = RES_BITS;
      end
      next_conversion_ready_pin_n = ~o_conversion_ready_pin_n;
      next_conversion_ready_pin_pulse = ~o_conversion_ready_pin_n;
      if (rdy_sel && new_cont)
      begin
        next_dout = ~o_dout;
        next_dout_pulse = ~o_dout;
      end
    end

    next_conv_run = (powered | sleep_pend) & start_s;
    next_ref_ctrl = regs[REF_CTRL_IDX][REF_CTRL_LSB +: REF_W];
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      sclk_prev <= 1'b0;
    else
      sclk_prev <= sclk_s;
    if (rst_all)
    begin
      state <= ST_CMD;
      bitcnt <= 3'h0;
      in_sh <= 7'h00;
      sh_out <= '0;
      out_bits <= 5'h00;
      reg_addr <= 4'h0;
      reg_left <= 4'h0;
      reg_wr <= 1'b0;
      for (int i = 0; i < NREG; i++)
        regs[i] <= REG_DFLT;
      result <= '0;
      cont_rd <= 1'b1;
      mode_pend <= 1'b0;
      mode_val <= 1'b0;
      powered <= 1'b1;
      sleep_pend <= 1'b0;
      idle_cnt <= 7'h00;
      dout_pulse <= 1'b0;
      conversion_ready_pin_pulse <= 1'b0;
      o_dout <= 1'b0;
      o_dout_oe <= 1'b0;
      o_conversion_ready_pin_n <= 1'b1;
      o_conv_run <= 1'b0;
      o_filter_restart <= 1'b1;
      o_cal_start <= 1'b0;
      o_cal_kind <= CAL_SYS_OFS;
      o_ref_ctrl <= '0;
    end
    else
    begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      in_sh <= next_in_sh;
      sh_out <= next_sh_out;
      out_bits <= next_out_bits;
      reg_addr <= next_reg_addr;
      reg_left <= next_reg_left;
      reg_wr <= next_reg_wr;
      regs <= next_regs;
      result <= next_result;
      cont_rd <= next_cont_rd;
      mode_pend <= next_mode_pend;
      mode_val <= next_mode_val;
      powered <= next_powered;
      sleep_pend <= next_sleep_pend;
      idle_cnt <= next_idle_cnt;
      dout_pulse <= next_dout_pulse;
      conversion_ready_pin_pulse <= next_conversion_ready_pin_pulse;
      o_dout <= next_dout;
      o_dout_oe <= next_dout_oe;
      o_conversion_ready_pin_n <= next_conversion_ready_pin_n;
      o_conv_run <= next_conv_run;
      o_filter_restart <= next_filter_restart;
      o_cal_start <= next_cal_start;
      o_cal_kind <= next_cal_kind;
      o_ref_ctrl <= next_ref_ctrl;
    end
  end

endmodule : acp_cmd_port

// ===== design/acp_pkg.sv
// Shared constants and types for the converter's serial command port.
package acp_pkg;

  // Result word and saturation codes.
  localparam int RES_W = 24;
  localparam logic [RES_W-1:0] RES_MAX = 24'h7fffff;
  localparam logic [RES_W-1:0] RES_MIN = 24'h800000;
  localparam logic [4:0] RES_BITS = 5'h18;
  localparam logic [4:0] BYTE_BITS = 5'h08;

  // Serial framing.
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [6:0] IDLE_TIMEOUT = 7'h40;

  // Single-byte commands, compared on bits 7..1 (bit 0 is don't care).
  localparam logic [6:0] OP_POWER_UP = 7'h00;
  localparam logic [6:0] OP_POWER_DOWN = 7'h01;
  localparam logic [6:0] OP_RESYNC = 7'h02;
  localparam logic [6:0] OP_SOFT_RESET = 7'h03;
  localparam logic [6:0] OP_READ_ONCE = 7'h09;
  localparam logic [6:0] OP_CONT_READ = 7'h0a;
  localparam logic [6:0] OP_STOP_READ = 7'h0b;

  // Register access commands, compared on the upper nibble.
  localparam logic [3:0] NIB_REG_READ = 4'h2;
  localparam logic [3:0] NIB_REG_WRITE = 4'h4;
  localparam logic [3:0] NIB_COUNT = 4'h0;

  // Full-byte commands.
  localparam logic [7:0] CMD_SYS_OFS_CAL = 8'h60;
  localparam logic [7:0] CMD_SYS_GAIN_CAL = 8'h61;
  localparam logic [7:0] CMD_INT_OFS_CAL = 8'h62;
  localparam logic [7:0] NO_OPERATION_BYTE = 8'hff;
  localparam logic [7:0] RESERVED_BYTE = 8'hf1;

  // Configuration register file.
  localparam int NREG = 16;
  localparam logic [7:0] REG_DFLT = 8'h00;
  localparam logic [3:0] RDY_SEL_IDX = 4'ha;
  localparam int RDY_SEL_BIT = 3;
  localparam logic [3:0] REF_CTRL_IDX = 4'h2;
  localparam int REF_CTRL_LSB = 5;
  localparam int REF_W = 2;

  // Synchroniser reset image: {start, reset_n, din, sclk, cs_n}.
  localparam logic [4:0] PIN_RST = 5'h09;

  typedef enum logic [1:0] {
    CAL_SYS_OFS = 2'h0,
    CAL_SYS_GAIN = 2'h1,
    CAL_INT_OFS = 2'h2
  } acp_cal_t;

  typedef enum logic [3:0] {
    ST_CMD = 4'h1,
    ST_COUNT = 4'h2,
    ST_WDATA = 4'h4,
    ST_RDOUT = 4'h8
  } acp_state_t;

endpackage : acp_pkg

// ===== design/acp_pin_sync.sv
// Two-flop synchroniser bank for pins arriving from outside the clock domain.
`timescale 1ns/1ps
module acp_pin_sync
#(
  parameter int W = 5,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Pins
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync;

  always_comb
  begin
    next_stage1 = i_async;
    next_sync = stage1;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      stage1 <= RST_VAL;
      o_sync <= RST_VAL;
    end
    else
    begin
      stage1 <= next_stage1;
      o_sync <= next_sync;
    end
  end

endmodule : acp_pin_sync

// ===== sim/acp_cmd_port_properties.sv
// Pin-level property checker for the serial command port.
`timescale 1ns/1ps
module acp_cmd_port_chk
#(
  parameter int RAW_W = 26
)
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Serial and control pins
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_din,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic o_dout,
  input wire logic o_dout_oe,
  input wire logic o_conversion_ready_pin_n,
  // Converter core
  input wire logic i_conv_done,
  input wire logic signed [RAW_W-1:0] i_conv_raw,
  input wire logic o_conv_run,
  input wire logic o_filter_restart,
  input wire logic o_cal_start,
  input wire acp_pkg::acp_cal_t o_cal_kind,
  input wire logic [acp_pkg::REF_W-1:0] o_ref_ctrl
);
  import acp_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  // The reset pin reaches the logic through flops, so checks pause while it is low.
  default disable iff (i_srst || !i_reset_n);
  property p_oe_off; i_cs_n [*4] |-> !o_dout_oe; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("shared pin driven while deselected");
  property p_oe_on; !i_cs_n [*4] |-> o_dout_oe; endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("shared pin not driven while selected");
  property p_rdy_set; i_conv_done && o_conversion_ready_pin_n |=> !o_conversion_ready_pin_n; endproperty
  a_rdy_set: assert property (p_rdy_set)
    else $error("ready pin did not fall on new data");
  property p_rdy_pulse; i_conv_done && !o_conversion_ready_pin_n |=> o_conversion_ready_pin_n ##1 !o_conversion_ready_pin_n; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("ready pin missed its high pulse");
  property p_rdy_clr; $fell(i_sclk) ##1 !i_conv_done [*6] |-> o_conversion_ready_pin_n; endproperty
  a_rdy_clr: assert property (p_rdy_clr)
    else $error("ready pin not released by serial clock");
  property p_cal_one; o_cal_start |=> !o_cal_start; endproperty
  a_cal_one: assert property (p_cal_one)
    else $error("calibration start longer than one cycle");
  property p_kind_hold; !o_cal_start |-> $stable(o_cal_kind); endproperty
  a_kind_hold: assert property (p_kind_hold)
    else $error("calibration kind moved without a start");
  property p_run_start; !i_start [*4] |-> !o_conv_run; endproperty
  a_run_start: assert property (p_run_start)
    else $error("converter runs with run pin low");
  property p_cal_refused; !o_conv_run |-> !o_cal_start; endproperty
  a_cal_refused: assert property (p_cal_refused)
    else $error("calibration started while stopped");
  c_rdy_pulse: cover property (i_conv_done && !o_conversion_ready_pin_n);
  c_cal: cover property (o_cal_start);
  c_restart: cover property (o_filter_restart);
endmodule : acp_cmd_port_chk

bind acp_cmd_port acp_cmd_port_chk #(.RAW_W(RAW_W)) i_chk (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_cs_n(i_cs_n), .i_sclk(i_sclk),
  .i_din(i_din), .i_reset_n(i_reset_n), .i_start(i_start), .o_dout(o_dout),
  .o_dout_oe(o_dout_oe), .o_conversion_ready_pin_n(o_conversion_ready_pin_n), .i_conv_done(i_conv_done),
  .i_conv_raw(i_conv_raw), .o_conv_run(o_conv_run), .o_filter_restart(o_filter_restart),
  .o_cal_start(o_cal_start), .o_cal_kind(o_cal_kind), .o_ref_ctrl(o_ref_ctrl));

// ===== sim/acp_host_model.sv
// Behavioural serial host that frames whole bytes toward the command port.
`timescale 1ns/1ps
module acp_host_model
(
  // Clock
  input wire logic i_ref_clk,
  // Serial pins
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_din,
  input wire logic i_dout
);
  import acp_pkg::*;
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_din = 1'b1;
  end

  // One 800 ns serial clock; the clock idles low between bits and frames.
  task automatic bit1(input logic b, output logic r);
    o_din = b;
    o_sclk = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    o_sclk = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    r = i_dout;
  endtask : bit1

  task automatic xfer8(input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'hff;
    if (tx !== RESERVED_BYTE)
      for (int i = 7; i >= 0; i--) bit1(tx[i], rx[i]);
  endtask : xfer8

  task automatic read24(output logic [23:0] d);
    for (int i = 2; i >= 0; i--) xfer8(NO_OPERATION_BYTE, d[8*i+:8]);
  endtask : read24

  // Select changes wait out the pin synchroniser before any clocking.
  task automatic sel(input logic lvl);
    o_cs_n = lvl;
    repeat (4) @(negedge i_ref_clk);
  endtask : sel
endmodule : acp_host_model

// ===== sim/tb.sv
// Self-checking bench for the serial command port driven by a host model.
`timescale 1ns/1ps
module tb;
  import acp_pkg::*;
  logic clk;
  logic srst;
  logic reset_n;
  logic start;
  logic conv_done;
  logic signed [25:0] conv_raw;
  logic cs_n, sclk, din, dout, dout_oe, conversion_ready_pin_n, conv_run, restart, cal_start;
  logic [1:0] ref_ctrl;
  logic [2:0] pv;
  logic [7:0] rx, d1, d2, b;
  logic [23:0] w;
  logic signed [25:0] cases [8];
  logic [7:0] ops [7] = '{8'h60, 8'h61, 8'h62, 8'h04, 8'h30, 8'hff, 8'h06};
  acp_cal_t cal_kind;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int cal_cnt = 0;
  int rst_cnt = 0;
  int n1, n2;
  wire pin = dout_oe ? dout : 1'bz;

  always #50 clk = ~clk;

  acp_host_model i_host (.i_ref_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din),
    .i_dout(pin));
  acp_cmd_port #(.RAW_W(26)) i_dut (.i_ref_clk(clk), .i_srst(srst), .i_cs_n(cs_n),
    .i_sclk(sclk), .i_din(din), .i_reset_n(reset_n), .i_start(start), .o_dout(dout),
    .o_dout_oe(dout_oe), .o_conversion_ready_pin_n(conversion_ready_pin_n), .i_conv_done(conv_done), .i_conv_raw(conv_raw),
    .o_conv_run(conv_run), .o_filter_restart(restart), .o_cal_start(cal_start),
    .o_cal_kind(cal_kind), .o_ref_ctrl(ref_ctrl));

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cal_start === 1'b1)
      cal_cnt <= cal_cnt + 1;
    if (restart === 1'b1)
      rst_cnt <= rst_cnt + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      results();
    end
  end

  task automatic results();
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  function automatic logic [23:0] sat(input logic signed [25:0] r);
    if (r > 26'sh07fffff)
      return RES_MAX;
    if (r < -26'sh0800000)
      return RES_MIN;
    return r[23:0];
  endfunction : sat

  // Records the shared pin before the pulse and one and two cycles after it.
  task automatic done(input logic signed [25:0] r);
    @(negedge clk);
    pv[2] = pin;
    conv_done = 1'b1;
    conv_raw = r;
    @(negedge clk);
    conv_done = 1'b0;
    pv[1] = pin;
    @(negedge clk);
    pv[0] = pin;
    repeat (3) @(negedge clk);
  endtask : done

  task automatic send(input logic [7:0] c);
    i_host.xfer8(c, rx);
  endtask : send

  task automatic rd(input logic [23:0] e, input string m);
    i_host.read24(w);
    chk(w, e, m);
  endtask : rd

  task automatic register_read_command(input logic [3:0] a, input logic [7:0] e, input string m);
    send({4'h2, a});
    send(8'h00);
    send(NO_OPERATION_BYTE);
    chk(24'(rx), 24'(e), m);
  endtask : register_read_command

  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    reset_n = 1'b1;
    start = 1'b1;
    conv_done = 1'b0;
    conv_raw = 26'sh0000000;
    void'($urandom(89));
    cases = '{26'sh07fffff, 26'sh0800000, -26'sh0800000, -26'sh0800001,
      26'sh1ffffff, 26'sh2000000, 26'sh0000000, 26'sh0000000};
    cases[6] = 26'($urandom);
    cases[7] = 26'($signed(24'($urandom)));
    d1 = 8'($urandom);
    d2 = ~d1;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    i_host.sel(1'b0);
    foreach (cases[i])
    begin
      done(cases[i]);
      rd(sat(cases[i]), "result");
    end
    send(8'h4f);
    send(8'h01);
    send(d1);
    send(d2);
    send(8'h42);
    send(8'h00);
    send(d1);
    repeat (6) @(negedge clk);
    chk(24'(ref_ctrl), 24'(d1[6:5]), "reference bits");
    // A broken byte must not survive a deselect.
    repeat (3) i_host.bit1(1'b0, b[0]);
    i_host.sel(1'b1);
    i_host.sel(1'b0);
    send(8'h2f);
    send(8'h01);
    send(NO_OPERATION_BYTE);
    chk(24'(rx), 24'(d1), "wrap first");
    send(NO_OPERATION_BYTE);
    chk(24'(rx), 24'(d2), "wrap second");
    foreach (ops[k])
    begin
      b = ops[k] | ((ops[k] < 8'h10) ? 8'($urandom_range(1)) : 8'h00);
      n1 = cal_cnt;
      n2 = rst_cnt;
      send(b);
      repeat (6) @(negedge clk);
      chk(24'(cal_cnt - n1), 24'(ops[k][7:4] == 4'h6), "cal pulses");
      chk(24'(rst_cnt - n2), 24'(ops[k][7:4] == 4'h0), "restarts");
      if (ops[k][7:4] == 4'h6)
        chk(24'(cal_kind), 24'(ops[k][1:0]), "cal kind");
    end
    register_read_command(4'h2, 8'h00, "soft reset");
    send(8'h4a);
    send(8'h00);
    send(8'h08);
    send(NO_OPERATION_BYTE);
    done(26'sh0123456);
    chk(24'(pv), 24'(3'b100), "ready fall");
    rd(24'h123456, "ready result");
    done(26'sh0000002);
    chk(24'(pv), 24'(3'b010), "ready pulse");
    rd(24'h000002, "second result");
    send(NO_OPERATION_BYTE);
    chk(24'(rx), 24'(8'hff), "forced high");
    send(8'h16);
    done(26'sh0000000);
    done(26'sh0000abc);
    chk(24'(pv), 24'(3'b111), "stop mode pin");
    send(8'h12 | 8'($urandom_range(1)));
    rd(24'h000abc, "read once");
    start = 1'b0;
    repeat (6) @(negedge clk);
    chk(24'(conv_run), 24'h0, "run pin low");
    n1 = cal_cnt;
    send(CMD_SYS_GAIN_CAL);
    send(8'h13);
    rd(24'h000abc, "repeat read");
    chk(24'(cal_cnt - n1), 24'h0, "refused cal");
    start = 1'b1;
    send(8'h14 | 8'($urandom_range(1)));
    done(26'sh0000000);
    done(-26'sh0000100);
    rd(24'hffff00, "continuous again");
    send(8'h02 | 8'($urandom_range(1)));
    chk(24'(conv_run), 24'h1, "sleep pending");
    done(26'sh0000000);
    chk(24'(conv_run), 24'h0, "asleep");
    n1 = cal_cnt;
    send(CMD_INT_OFS_CAL);
    repeat (6) @(negedge clk);
    chk(24'(cal_cnt - n1), 24'h0, "cal while asleep");
    send(8'h00 | 8'($urandom_range(1)));
    repeat (6) @(negedge clk);
    chk(24'(conv_run), 24'h1, "awake");
    repeat (3) i_host.bit1(1'b1, b[0]);
    repeat (64) done(26'sh0000000);
    register_read_command(4'ha, 8'h08, "idle timeout");
    i_host.sel(1'b1);
    reset_n = 1'b0;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    i_host.sel(1'b0);
    register_read_command(4'ha, 8'h00, "hardware reset");
    i_host.sel(1'b1);
    results();
  end
endmodule : tb
